// >>> shared/asmc_defines.vh
`ifndef ASMC_DEFINES_VH
`define ASMC_DEFINES_VH

// Clock period in picoseconds (100 MHz)
`define ASMC_CLK_PS 10000
`define ASMC_ADDR_W 19
`define ASMC_DATA_W 32
`define ASMC_LANES 4
`define ASMC_LANE_W 8

// Speed grade encodings on the grade input
`define ASMC_GRADE_12 2'h0
`define ASMC_GRADE_15 2'h1
`define ASMC_GRADE_17 2'h2

// Times in picoseconds, per grade 12 / 15 / 17
`define ASMC_CYCLE_12_PS 12000
`define ASMC_CYCLE_15_PS 15000
`define ASMC_CYCLE_17_PS 17000
`define ASMC_ACCESS_12_PS 12000
`define ASMC_ACCESS_15_PS 15000
`define ASMC_ACCESS_17_PS 17000
`define ASMC_GATE_ON_12_PS 12000
`define ASMC_GATE_ON_15_PS 12000
`define ASMC_GATE_ON_17_PS 13000
`define ASMC_FLOAT_12_PS 6000
`define ASMC_FLOAT_15_PS 7000
`define ASMC_FLOAT_17_PS 8000

// Least times round up, longest waits also round up (wait out the max)
`define ASMC_CYC(ps) (((ps) + `ASMC_CLK_PS - 1) / `ASMC_CLK_PS)

`define ASMC_CNT_W 3
`define ASMC_CNT_ONE 3'h1
`define ASMC_CNT_ZERO 3'h0
// Extra cycles so read data has crossed both capture flops
`define ASMC_SYNC_CYC 3'h2

`endif

// >>> design/asmc_timer.v
`timescale 1ns/100ps
`include "asmc_defines.vh"

// Down counter: load a count, pulse done in the cycle after it reaches one, as it reads zero.
module asmc_timer (
  input wire ref_clk,
  input wire rstn,
  input wire load,
  input wire [`ASMC_CNT_W-1:0] count,
  output reg done
);
  reg [`ASMC_CNT_W-1:0] cnt_reg;

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= `ASMC_CNT_ZERO;
      done <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      done <= 1'b0;
    end else begin
      done <= (cnt_reg == `ASMC_CNT_ONE);
      if (cnt_reg != `ASMC_CNT_ZERO)
        cnt_reg <= cnt_reg - `ASMC_CNT_ONE;
    end
  end
endmodule

// >>> design/asmc_host.v
// Contract
// - Next cycle waits out the cycle time
// - Write strobe stays high during reads
// - Address valid long before write end
// - Select held long before write end
// - Write pulse minimum with enable off
// - Longer write pulse with enable on
// - Address valid by write start
// - Address steady until write end
// - Write data leads and holds write end
// - Never drive bus against reading device
// - One select per byte lane, low first
`timescale 1ns/100ps
`include "asmc_defines.vh"

module asmc_host (
  input wire ref_clk,
  input wire rstn,
  input wire [1:0] grade,
  input wire req_valid,
  input wire req_write,
  input wire [`ASMC_ADDR_W-1:0] req_addr,
  input wire [`ASMC_LANES-1:0] req_lanes,
  input wire [`ASMC_DATA_W-1:0] req_wdata,
  output reg req_ready,
  output reg rsp_valid,
  output reg [`ASMC_DATA_W-1:0] rsp_rdata,
  output reg [`ASMC_ADDR_W-1:0] address_lines,
  output reg [`ASMC_LANES-1:0] lane_select_n,
  output reg write_strobe_n,
  output reg output_gate_n,
  input wire [`ASMC_DATA_W-1:0] data_lines_in,
  output reg [`ASMC_DATA_W-1:0] data_lines_out,
  output reg [`ASMC_DATA_W-1:0] data_lines_oe
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_READ = 5'h02;
  localparam [4:0] ST_WRITE = 5'h04;
  localparam [4:0] ST_WEND = 5'h08;
  localparam [4:0] ST_GAP = 5'h10;

  reg [4:0] state_reg;
  reg [`ASMC_DATA_W-1:0] sync1_reg;
  reg [`ASMC_DATA_W-1:0] sync2_reg;
  reg [1:0] grade_reg;
  reg tmr_load;
  reg [`ASMC_CNT_W-1:0] tmr_count;
  wire tmr_done;
  wire [`ASMC_DATA_W-1:0] lane_mask;

  // Cycle counts per grade, all derived from picosecond figures
  function [`ASMC_CNT_W-1:0] cyc_of;
    input [1:0] g;
    input [1:0] kind;
    integer c;
    begin
      c = 0;
      case (kind)
        2'h0: begin
          case (g)
            `ASMC_GRADE_15: c = `ASMC_CYC(`ASMC_ACCESS_15_PS);
            `ASMC_GRADE_17: c = `ASMC_CYC(`ASMC_ACCESS_17_PS);
            default: c = `ASMC_CYC(`ASMC_ACCESS_12_PS);
          endcase
        end
        2'h1: begin
          case (g)
            `ASMC_GRADE_15: c = `ASMC_CYC(`ASMC_GATE_ON_15_PS);
            `ASMC_GRADE_17: c = `ASMC_CYC(`ASMC_GATE_ON_17_PS);
            default: c = `ASMC_CYC(`ASMC_GATE_ON_12_PS);
          endcase
        end
        2'h2: begin
          case (g)
            `ASMC_GRADE_15: c = `ASMC_CYC(`ASMC_FLOAT_15_PS);
            `ASMC_GRADE_17: c = `ASMC_CYC(`ASMC_FLOAT_17_PS);
            default: c = `ASMC_CYC(`ASMC_FLOAT_12_PS);
          endcase
        end
        default: begin
          case (g)
            `ASMC_GRADE_15: c = `ASMC_CYC(`ASMC_CYCLE_15_PS);
            `ASMC_GRADE_17: c = `ASMC_CYC(`ASMC_CYCLE_17_PS);
            default: c = `ASMC_CYC(`ASMC_CYCLE_12_PS);
          endcase
        end
      endcase
      // Counts are small; keep only the counter's width
      cyc_of = c[`ASMC_CNT_W-1:0];
    end
  endfunction

  genvar i;
  generate
    for (i = 0; i < `ASMC_LANES; i = i + 1) begin : g_lane
      // Lane i select covers bits 8i..8i+7
      assign lane_mask[i*`ASMC_LANE_W +: `ASMC_LANE_W] =
        {`ASMC_LANE_W{req_lanes[i]}};
    end
  endgenerate

  asmc_timer u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Read data comes from pins, so two flops before use
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync1_reg <= {`ASMC_DATA_W{1'b0}};
      sync2_reg <= {`ASMC_DATA_W{1'b0}};
    end else begin
      sync1_reg <= data_lines_in;
      sync2_reg <= sync1_reg;
    end
  end

  always @* begin
    tmr_load = 1'b0;
    tmr_count = `ASMC_CNT_ZERO;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          tmr_load = 1'b1;
          // Gate stays off in writes, yet the longer pulse covers both
          // Read waits the access time plus the capture flops in one run
          tmr_count = req_write ? cyc_of(grade, 2'h1) :
            cyc_of(grade, 2'h0) + `ASMC_SYNC_CYC;
        end
      end
      ST_WRITE: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc_of(grade_reg, 2'h3);
        end
      end
      ST_READ: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_count = cyc_of(grade_reg, 2'h2);
        end
      end
      default: begin
        tmr_load = 1'b0;
        tmr_count = `ASMC_CNT_ZERO;
      end
    endcase
  end

  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      grade_reg <= `ASMC_GRADE_12;
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= {`ASMC_DATA_W{1'b0}};
      address_lines <= {`ASMC_ADDR_W{1'b0}};
      lane_select_n <= {`ASMC_LANES{1'b1}};
      write_strobe_n <= 1'b1;
      output_gate_n <= 1'b1;
      data_lines_out <= {`ASMC_DATA_W{1'b0}};
      data_lines_oe <= {`ASMC_DATA_W{1'b0}};
    end else begin
      rsp_valid <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          req_ready <= 1'b1;
          if (req_valid && req_ready) begin
            req_ready <= 1'b0;
            grade_reg <= grade;
            // Address, selects and strobe all move on one edge
            address_lines <= req_addr;
            lane_select_n <= ~req_lanes;
            if (req_write) begin
              write_strobe_n <= 1'b0;
              output_gate_n <= 1'b1;
              data_lines_out <= req_wdata;
              data_lines_oe <= lane_mask;
              state_reg <= ST_WRITE;
            end else begin
              write_strobe_n <= 1'b1;
              output_gate_n <= 1'b0;
              data_lines_oe <= {`ASMC_DATA_W{1'b0}};
              state_reg <= ST_READ;
            end
          end
        end
        ST_READ: begin
          // The timer pulses done once only, so sample on that pulse
          if (tmr_done) begin
            // Sample the synchronised bus only after the access time
            rsp_rdata <= sync2_reg & lane_mask_of(lane_select_n);
            rsp_valid <= 1'b1;
            output_gate_n <= 1'b1;
            lane_select_n <= {`ASMC_LANES{1'b1}};
            state_reg <= ST_GAP;
          end
        end
        ST_WRITE: begin
          // Strobe rises first; address, selects and data still hold
          if (tmr_done) begin
            write_strobe_n <= 1'b1;
            state_reg <= ST_WEND;
          end
        end
        ST_WEND: begin
          lane_select_n <= {`ASMC_LANES{1'b1}};
          data_lines_oe <= {`ASMC_DATA_W{1'b0}};
          state_reg <= ST_GAP;
        end
        ST_GAP: begin
          if (tmr_done) begin
            req_ready <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Keep only the lanes that were selected
  function [`ASMC_DATA_W-1:0] lane_mask_of;
    input [`ASMC_LANES-1:0] sel_n;
    integer k;
    begin
      lane_mask_of = {`ASMC_DATA_W{1'b0}};
      for (k = 0; k < `ASMC_LANES; k = k + 1)
        lane_mask_of[k*`ASMC_LANE_W +: `ASMC_LANE_W] =
          {`ASMC_LANE_W{~sel_n[k]}};
    end
  endfunction
endmodule

// >>> sim/asmc_mem_model.sv
`timescale 1ns/100ps
module asmc_mem_model #(parameter int DLY = 8) (
  input wire [18:0] address_lines,
  input wire [3:0] lane_select_n,
  input wire write_strobe_n,
  input wire output_gate_n,
  input wire [31:0] data_lines_out,
  input wire [31:0] data_lines_oe,
  output logic [31:0] data_lines_in
);
  logic [31:0] mem [0:1023];
  logic [31:0] rd;
  logic [31:0] drv;
  logic [31:0] junk = 32'ha5a5_3c3c;
  logic [3:0] wr;
  logic [3:0] wr_q = 4'h0;
  integer k;
  integer j;
  // Released lines wander so a stale value never passes as read data
  always #7 junk = ~junk;
  assign #(DLY) rd = mem[address_lines[9:0]];
  always @* begin
    for (k = 0; k < 4; k++) begin
      wr[k] = !lane_select_n[k] && !write_strobe_n;
      drv[8*k+:8] = {8{!lane_select_n[k] && !output_gate_n &&
                       write_strobe_n}};
    end
  end
  // Store at the end of the overlap, when the host data must be held
  always @(wr) begin
    for (j = 0; j < 4; j++)
      if (wr_q[j] && !wr[j])
        mem[address_lines[9:0]][8*j+:8] = data_lines_out[8*j+:8];
    wr_q = wr;
  end
  assign data_lines_in = (data_lines_oe & data_lines_out) |
    (~data_lines_oe & drv & rd) | (~data_lines_oe & ~drv & junk);
endmodule

// >>> sim/asmc_host_assertions.sv
`timescale 1ns/100ps
module asmc_host_assertions (
  input wire ref_clk,
  input wire rstn,
  input wire rsp_valid,
  input wire [18:0] address_lines,
  input wire [3:0] lane_select_n,
  input wire write_strobe_n,
  input wire output_gate_n,
  input wire [31:0] data_lines_out,
  input wire [31:0] data_lines_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_rd_strobe;
    !output_gate_n |-> write_strobe_n;
  endproperty
  a_rd_strobe: assert property (p_rd_strobe)
    else $error("strobe low in read");
  property p_contend;
    !output_gate_n && write_strobe_n |-> data_lines_oe == 32'h0;
  endproperty
  a_contend: assert property (p_contend)
    else $error("host drives against read");
  property p_pulse;
    $fell(write_strobe_n) |-> !write_strobe_n [*2];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("write pulse short");
  property p_addr_hold;
    !write_strobe_n |=> $stable(address_lines) && $stable(lane_select_n);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or select moved in write");
  property p_data_end;
    $rose(write_strobe_n) |-> data_lines_oe != 32'h0 &&
      $past(data_lines_oe) != 32'h0 && $stable(data_lines_out);
  endproperty
  a_data_end: assert property (p_data_end)
    else $error("write data not held to end");
  property p_we_sel;
    $fell(write_strobe_n) |-> lane_select_n != 4'hf;
  endproperty
  a_we_sel: assert property (p_we_sel)
    else $error("strobe without select");
  property p_gap;
    $rose(&lane_select_n) |-> (&lane_select_n) [*2];
  endproperty
  a_gap: assert property (p_gap)
    else $error("cycle gap short");
  property p_access;
    $fell(output_gate_n) |-> !output_gate_n [*2];
  endproperty
  a_access: assert property (p_access)
    else $error("read access cut short");
  c_write: cover property ($rose(write_strobe_n));
  c_read: cover property (rsp_valid);
  c_lane: cover property (!write_strobe_n && lane_select_n == 4'he);
endmodule
bind asmc_host asmc_host_assertions u_chk (.ref_clk(ref_clk),
  .rstn(rstn), .rsp_valid(rsp_valid), .address_lines(address_lines),
  .lane_select_n(lane_select_n), .write_strobe_n(write_strobe_n),
  .output_gate_n(output_gate_n), .data_lines_out(data_lines_out),
  .data_lines_oe(data_lines_oe));

// >>> sim/asmc_host_tb.sv
`timescale 1ns/100ps
module asmc_host_tb;
  logic ref_clk = 0, rstn = 0, req_valid = 0, req_write = 0;
  logic [1:0] grade = 2'h0;
  logic [18:0] req_addr = 19'h0;
  logic [3:0] req_lanes = 4'h0;
  logic [31:0] req_wdata = 32'h0, shadow;
  wire req_ready, rsp_valid, write_strobe_n, output_gate_n;
  wire [31:0] rsp_rdata, data_lines_in, data_lines_out, data_lines_oe;
  wire [18:0] address_lines;
  wire [3:0] lane_select_n;
  int fails = 0, n_tests = 0;
  asmc_host DUT (.ref_clk(ref_clk), .rstn(rstn), .grade(grade),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
    .req_lanes(req_lanes), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .address_lines(address_lines), .lane_select_n(lane_select_n),
    .write_strobe_n(write_strobe_n), .output_gate_n(output_gate_n),
    .data_lines_in(data_lines_in), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe));
  asmc_mem_model #(.DLY(8)) mem (.address_lines(address_lines),
    .lane_select_n(lane_select_n), .write_strobe_n(write_strobe_n),
    .output_gate_n(output_gate_n), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] lm(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, s);
    n_tests++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  // Request held until an edge that sees ready high
  task automatic go(input logic w, input logic [18:0] a,
                    input logic [3:0] l, input logic [31:0] d);
    int n = 0;
    @(negedge ref_clk);
    req_write = w;
    req_addr = a;
    req_lanes = l;
    req_wdata = d;
    req_valid = 1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 50);
    if (n >= 50) fails++;
    @(negedge ref_clk);
    req_valid = 0;
  endtask
  task automatic rd(input logic [18:0] a, input logic [3:0] l,
                    input logic [31:0] e);
    int n = 0;
    go(0, a, l, 32'h0);
    while (rsp_valid !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk("rdata", e, rsp_rdata);
  endtask
  task automatic t_grades;
    for (int g = 0; g < 4; g++) begin
      @(negedge ref_clk);
      grade = g[1:0];
      go(1, 19'(g), 4'hf, 32'h1234_5678 ^ g);
      rd(19'(g), 4'hf, 32'h1234_5678 ^ g);
    end
  endtask
  task automatic t_lanes;
    logic [3:0] m [6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc};
    logic [31:0] d;
    shadow = 32'h0;
    go(1, 19'h10, 4'hf, 32'h0);
    for (int i = 0; i < 6; i++) begin
      d = 32'h3c5a_7e81 + i * 32'h1010_1010;
      go(1, 19'h10, m[i], d);
      shadow = (shadow & ~lm(m[i])) | (d & lm(m[i]));
      rd(19'h10, 4'hf, shadow);
      rd(19'h10, m[i], shadow & lm(m[i]));
    end
  endtask
  task automatic t_b2b;
    go(1, 19'h7ffff, 4'hf, 32'hdead_beef);
    go(1, 19'h7fffe, 4'hf, 32'h0f0f_f0f0);
    rd(19'h7ffff, 4'hf, 32'hdead_beef);
    rd(19'h7fffe, 4'hf, 32'h0f0f_f0f0);
  endtask
  task report_and_stop;
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    rstn = 1;
    repeat (2) @(negedge ref_clk);
    chk("idle_sel", 32'hf, {28'h0, lane_select_n});
    t_grades();
    t_lanes();
    t_b2b();
    report_and_stop();
  end
  initial begin
    #300000;
    fails++;
    report_and_stop();
  end
endmodule
